// ===== dl_report_defs.svh
// register offsets, field positions, reset values and fixed counts of the link status block
`ifndef DL_REPORT_DEFS_SVH
`define DL_REPORT_DEFS_SVH

// ==================================================
// register map
`define RX_LINK_STATUS_ADDR 8'hA9
`define REPORT_CTRL_ADDR 8'hAA
`define REPORT_CTRL_RESET 8'h00

// ==================================================
// receive status field positions
`define STAT_MSG_BIT 4
`define STAT_NEXT_BIT 3
`define STAT_EMPTY_BIT 2
`define STAT_NEAR_BIT 1
`define STAT_FULL_BIT 0

// ==================================================
// receive fifo and status entry
`define RX_FIFO_DEPTH 7'h40
`define EOM_GOOD 2'h0
`define EOM_FCS_ERR 2'h1
`define EOM_ABORT 2'h2
`define EOM_PARTIAL 2'h3

// ==================================================
// report framing
`define REPORT_OCTETS 4'hE
`define HEADER_OCTETS 4'h6
`define HIST_PAIRS 4
`define HDR_SAPI 6'h0E
`define HDR_TEI 8'h01
`define HDR_CTRL 8'h03
`define HDR_FILL 8'h00
`define PRIO_LINK_FIRST 2'h3
`define FDL_SLOT_VALUE 8'h40
`define TX_BUF_DEPTH 4
`define TX_BUF_WIDTH 8

// ==================================================
// crc error bands of one second
`define CRC_BAND2 16'h0002
`define CRC_BAND3 16'h0006
`define CRC_BAND4 16'h000B
`define CRC_BAND5 16'h0065
`define CRC_BAND6 16'h0140

`endif

// ===== dl_report_pkg.sv
// types shared by the link status and report generator
`default_nettype none
package dl_report_pkg;

  // ==================================================
  // report sequencer states, gray along idle-wait-send
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_SEND = 2'h3
  } report_state_e;

  // ==================================================
  // control register layout, msb first
  typedef struct packed {
    logic auto_report_enable;
    logic report_cmd_resp_bit;
    logic report_reserved_bit;
    logic report_user_bit_one;
    logic report_user_bit_two;
    logic report_slip_bit;
    logic auto_slip_select;
    logic report_send_now;
  } report_ctrl_s;

  // processor port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;

  // receive fifo events from the receiver and the data port
  typedef struct packed {
    logic push_data;
    logic push_status;
    logic pop;
    logic msg_active;
    logic head_is_status;
  } rx_event_s;

  // latched one-second error counts
  typedef struct packed {
    logic [15:0] crc;
    logic [15:0] fps;
    logic [15:0] lcv;
    logic [15:0] sef;
    logic [15:0] fred;
  } err_counts_s;

  // one second of report content, two octets
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } second_pair_s;

  // whole state of the main block
  typedef struct packed {
    logic [6:0] fill;
    logic [5:0] msg_cnt;
    logic near_q;
    logic full_q;
    report_ctrl_s ctrl;
    logic pending;
    report_state_e st;
    logic [3:0] idx;
    second_pair_s [3:0] hist;
    logic [1:0] seq;
    logic [7:0] rdata;
    logic [7:0] entry;
    logic entry_wr;
    logic near_irq;
    logic discard;
    logic slip_seen;
  } link_state_s;

endpackage
`default_nettype wire

// ===== tx_octet_buf.sv
// small valid/ready fifo between the report sequencer and the transmit channel
`default_nettype none
module tx_octet_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_state_s;

  buf_state_s q_r;
  buf_state_s q_nxt;
  logic push;
  logic pop;

  // ==================================================
  // handshakes, full and empty from the count
  assign in_ready_o = (q_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o = q_r.mem[q_r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // next state of pointers and storage
  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data_i;
      q_nxt.wp = (q_r.wp == AW'(DEPTH-1)) ? '0 : q_r.wp + 1'b1;
    end
    if (pop) begin
      q_nxt.rp = (q_r.rp == AW'(DEPTH-1)) ? '0 : q_r.rp + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== dl_report_gen.sv
// receive link fifo status and performance report generator
`default_nettype none
`include "dl_report_defs.svh"
module dl_report_gen
  import dl_report_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // parallel processor port
  input wire cpu_req_s cpu_req_i,
  output logic [7:0] cpu_rdata_o,
  // receive fifo events and threshold
  input wire rx_event_s rx_event_i,
  input wire logic [5:0] near_full_threshold_i,
  output logic [7:0] message_status_entry_o,
  output logic status_entry_write_o,
  output logic near_full_interrupt_o,
  output logic rx_discard_o,
  // report inputs
  input wire logic one_second_tick_i,
  input wire err_counts_s err_counts_i,
  input wire logic rx_frame_slip_i,
  input wire logic [1:0] codeword_priority_select_i,
  input wire logic tx_fifo_empty_i,
  // transmit channel
  output logic codeword_preempt_o,
  output logic report_busy_o,
  output logic [7:0] tx_octet_o,
  output logic tx_octet_valid_o,
  input wire logic tx_octet_ready_i
);

  link_state_s q_r;
  link_state_s q_nxt;
  logic [6:0] near_level;
  logic near_now;
  logic full_now;
  logic empty_now;
  logic [7:0] status_byte;
  logic push_ok;
  logic buf_ready;
  logic buf_valid;
  logic [7:0] octet;
  second_pair_s pair_now;

  // ==================================================
  // functions
  // one second of error counts coded into an octet pair
  function automatic second_pair_s code_second(err_counts_s c, logic slip, logic [1:0] seq);
    logic g1, g2, g3, g4, g5, g6;
    second_pair_s p;
    g1 = (c.crc == 16'h0001);
    g2 = (c.crc >= `CRC_BAND2) && (c.crc < `CRC_BAND3);
    g3 = (c.crc >= `CRC_BAND3) && (c.crc < `CRC_BAND4);
    g4 = (c.crc >= `CRC_BAND4) && (c.crc < `CRC_BAND5);
    g5 = (c.crc >= `CRC_BAND5) && (c.crc < `CRC_BAND6);
    g6 = (c.crc >= `CRC_BAND6);
    p.hi = {g3, (c.lcv != '0), g4, 1'b0, 1'b0, g5, slip, g6};
    p.lo = {(c.fps != '0), (c.sef != '0) || (c.fred != '0), 1'b0, g1, 1'b0, g2, seq};
    return p;
  endfunction

  // octet of the report at a given index, user bits overlaid from control
  function automatic logic [7:0] report_octet(logic [3:0] idx, second_pair_s [3:0] hist,
                                              report_ctrl_s ctrl);
    logic [7:0] o;
    logic [3:0] rel;
    second_pair_s p;
    rel = idx - `HEADER_OCTETS;
    p = hist[rel[2:1]];
    o = `HDR_FILL;
    if (idx == 4'h0) begin
      o = {`HDR_SAPI, ctrl.report_cmd_resp_bit, 1'b0};
    end else if (idx == 4'h1) begin
      o = `HDR_TEI;
    end else if (idx == 4'h2) begin
      o = `HDR_CTRL;
    end else if (idx >= `HEADER_OCTETS && !rel[0]) begin
      o = p.hi;
      o[4] = ctrl.report_user_bit_one;
      o[3] = ctrl.report_user_bit_two;
      if (!ctrl.auto_slip_select) begin
        o[1] = ctrl.report_slip_bit;
      end
    end else if (idx >= `HEADER_OCTETS) begin
      o = p.lo;
      o[3] = ctrl.report_reserved_bit;
    end
    return o;
  endfunction

  // ==================================================
  // receive fifo levels
  // empty, near and full levels
  assign near_level = `RX_FIFO_DEPTH - {1'b0, near_full_threshold_i};
  assign empty_now = (q_r.fill == '0);
  assign full_now = (q_r.fill == `RX_FIFO_DEPTH);
  assign near_now = (q_r.fill >= near_level);
  assign push_ok = (rx_event_i.push_data || rx_event_i.push_status) && !full_now;
  assign status_byte = {3'h0, rx_event_i.msg_active, rx_event_i.head_is_status,
                        empty_now, near_now, full_now};
  assign pair_now = code_second(err_counts_i, q_r.slip_seen, q_r.seq);
  assign octet = report_octet(q_r.idx, q_r.hist, q_r.ctrl);

  // ==================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.entry_wr = 1'b0;
    q_nxt.near_irq = 1'b0;
    q_nxt.discard = 1'b0;
    q_nxt.near_q = near_now;
    q_nxt.full_q = full_now;
    // slip seen during the current second, a slip on the tick counts for the next
    q_nxt.slip_seen = rx_frame_slip_i || (q_r.slip_seen && !one_second_tick_i);
    // fill count: writes refused while full, a read of an empty fifo is ignored
    // so that a push meeting it still counts
    if (push_ok && !(rx_event_i.pop && !empty_now)) begin
      q_nxt.fill = q_r.fill + 7'h01;
    end else if (rx_event_i.pop && !push_ok && !empty_now) begin
      q_nxt.fill = q_r.fill - 7'h01;
    end
    // byte count of message in progress
    if (rx_event_i.push_status) begin
      q_nxt.msg_cnt = '0;
    end else if (push_ok && rx_event_i.push_data) begin
      q_nxt.msg_cnt = q_r.msg_cnt + 6'h01;
    end
    // partial entry on reaching near full
    if (near_now && !q_r.near_q && rx_event_i.msg_active) begin
      q_nxt.entry = {`EOM_PARTIAL, q_r.msg_cnt};
      q_nxt.entry_wr = 1'b1;
      q_nxt.msg_cnt = '0;
    end
    // interrupt on the rising flag only
    if (near_now && !q_r.near_q) begin
      q_nxt.near_irq = 1'b1;
    end
    // overflow drops message, partial with zero count
    if (full_now && !q_r.full_q && rx_event_i.msg_active) begin
      q_nxt.entry = {`EOM_PARTIAL, 6'h00};
      q_nxt.entry_wr = 1'b1;
      q_nxt.discard = 1'b1;
      q_nxt.msg_cnt = '0;
    end
    // processor port: read data registered, control write
    if (cpu_req_i.rd) begin
      q_nxt.rdata = (cpu_req_i.addr == `RX_LINK_STATUS_ADDR) ? status_byte :
                    (cpu_req_i.addr == `REPORT_CTRL_ADDR) ? q_r.ctrl : 8'h00;
    end
    // one-shot cleared once the request is taken
    if (q_r.ctrl.report_send_now) begin
      q_nxt.ctrl.report_send_now = 1'b0;
    end
    if (cpu_req_i.wr && cpu_req_i.addr == `REPORT_CTRL_ADDR) begin
      q_nxt.ctrl = cpu_req_i.wdata;
    end
    // latch one second of counts into history
    if (one_second_tick_i) begin
      q_nxt.hist = {q_r.hist[2:0], pair_now};
      q_nxt.seq = q_r.seq + 2'h1;
    end
    // request sticky, set wins over take
    if ((one_second_tick_i && q_r.ctrl.auto_report_enable) || q_r.ctrl.report_send_now) begin
      q_nxt.pending = 1'b1;
    end else if (q_r.st == ST_IDLE && q_r.pending) begin
      q_nxt.pending = 1'b0;
    end
    // report sequencer
    case (q_r.st)
      ST_IDLE: begin
        if (q_r.pending) begin
          q_nxt.st = ST_WAIT;
          q_nxt.idx = '0;
        end
      end
      ST_WAIT: begin
        // wait for the transmit fifo to empty
        if (tx_fifo_empty_i) begin
          q_nxt.st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (buf_ready) begin
          q_nxt.idx = q_r.idx + 4'h1;
          if (q_r.idx == `REPORT_OCTETS - 4'h1) begin
            q_nxt.st = ST_IDLE;
          end
        end
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
      q_r.ctrl <= `REPORT_CTRL_RESET;
      q_r.st <= ST_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==================================================
  // outputs
  assign cpu_rdata_o = q_r.rdata;
  assign message_status_entry_o = q_r.entry;
  assign status_entry_write_o = q_r.entry_wr;
  assign near_full_interrupt_o = q_r.near_irq;
  assign rx_discard_o = q_r.discard;
  assign report_busy_o = (q_r.st != ST_IDLE);
  // link first mode preempts codeword output
  assign codeword_preempt_o = (q_r.st == ST_SEND) &&
                              (codeword_priority_select_i == `PRIO_LINK_FIRST);
  assign buf_valid = (q_r.st == ST_SEND);

  // transmit octet buffer, back-pressure stalls the sequencer
  tx_octet_buf #(
    .WIDTH(`TX_BUF_WIDTH),
    .DEPTH(`TX_BUF_DEPTH)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(octet),
    .in_valid_i(buf_valid),
    .in_ready_o(buf_ready),
    .out_data_o(tx_octet_o),
    .out_valid_o(tx_octet_valid_o),
    .out_ready_i(tx_octet_ready_i)
  );

  // ==================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_empty_after_drain: assert property (
    (q_r.fill == 7'h01 && rx_event_i.pop && !rx_event_i.push_data && !rx_event_i.push_status)
    |=> empty_now) else $error("empty flag not set after last read");
  chk_near_threshold: assert property (
    status_byte[1] == (({1'b0, q_r.fill} + {2'h0, near_full_threshold_i}) >= 8'h40))
    else $error("near-full flag disagrees with fill");
  chk_partial_rewrite: assert property (
    (near_now && !q_r.near_q && rx_event_i.msg_active && !full_now)
    |=> status_entry_write_o && message_status_entry_o[7:6] == 2'h3)
    else $error("no partial entry at near full");
  chk_near_irq_edge: assert property (
    near_full_interrupt_o |-> !$past(q_r.near_q) && $past(near_now))
    else $error("near-full interrupt without fresh flag");
  chk_full_refuse: assert property (
    (full_now && !rx_event_i.pop) |=> full_now)
    else $error("full fifo accepted a write");
  chk_full_discard: assert property (
    (full_now && !q_r.full_q && rx_event_i.msg_active)
    |=> rx_discard_o && message_status_entry_o == 8'hC0)
    else $error("overflow not reported as partial zero");
  chk_read_when_full: assert property (
    (full_now && rx_event_i.pop && !rx_event_i.push_data && !rx_event_i.push_status)
    |=> q_r.fill == 7'h3F) else $error("read from full fifo lost");
  chk_auto_request: assert property (
    (one_second_tick_i && q_r.ctrl.auto_report_enable) |=> q_r.pending || report_busy_o)
    else $error("tick did not request a report");
  chk_preempt_mode: assert property (
    (q_r.st == ST_SEND && codeword_priority_select_i == 2'h3) |-> codeword_preempt_o)
    else $error("codeword not preempted");
  chk_wait_empty: assert property (
    (q_r.st == ST_WAIT && !tx_fifo_empty_i) |=> q_r.st == ST_WAIT)
    else $error("report left wait before fifo empty");
  chk_send_now_once: assert property (
    q_r.ctrl.report_send_now && !cpu_req_i.wr |=> !q_r.ctrl.report_send_now ##1 q_r.pending
    || report_busy_o) else $error("send-now not taken as one shot");
  chk_slip_select: assert property (
    (buf_valid && q_r.idx == 4'h6 && !q_r.ctrl.auto_slip_select)
    |-> octet[1] == q_r.ctrl.report_slip_bit) else $error("written slip bit not sent");

endmodule
`default_nettype wire

// ===== far_link_term.sv
// far-end terminal model that drains report octets from the transmit channel
`default_nettype none
module far_link_term (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // transmit channel
  input wire logic [7:0] octet_i,
  input wire logic valid_i,
  output logic ready_o,
  // pacing: slow takes one octet in four cycles
  input wire logic slow_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic [1:0] pace_r;
  // ==================================================
  // accept an octet at each edge where valid and ready meet
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pace_r <= 2'h0;
      ready_o <= 1'b0;
    end else begin
      pace_r <= pace_r + 2'h1;
      ready_o <= !slow_i || (pace_r == 2'h3);
      if (valid_i && ready_o) begin
        got.push_back(octet_i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dl_report_gen_test.sv
// self-checking bench for the link status and report generator
`default_nettype none
`include "dl_report_defs.svh"
module dl_report_gen_test
  import dl_report_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_n_i, tick, slip, txe, slow;
  cpu_req_s cpu_req;
  rx_event_s rx_ev;
  err_counts_s errs;
  logic [5:0] thr;
  logic [1:0] prio;
  logic [7:0] rdata, entry, octet, rv, last_entry;
  logic entry_wr, irq, disc, preempt, busy, ovalid, oready;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_irq = 0;
  int n_disc = 0;
  int n_pre = 0;

  // ==================================================
  // design and far end
  dl_report_gen dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cpu_req_i(cpu_req),
    .cpu_rdata_o(rdata), .rx_event_i(rx_ev), .near_full_threshold_i(thr),
    .message_status_entry_o(entry), .status_entry_write_o(entry_wr),
    .near_full_interrupt_o(irq), .rx_discard_o(disc), .one_second_tick_i(tick),
    .err_counts_i(errs), .rx_frame_slip_i(slip), .codeword_priority_select_i(prio),
    .tx_fifo_empty_i(txe), .codeword_preempt_o(preempt), .report_busy_o(busy),
    .tx_octet_o(octet), .tx_octet_valid_o(ovalid), .tx_octet_ready_i(oready));
  far_link_term far_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .octet_i(octet),
    .valid_i(ovalid), .ready_o(oready), .slow_i(slow));

  // clock of 10 ns
  always #5 ref_clk_i = ~ref_clk_i;

  // count the design's pulses mid-cycle, where they have settled
  always @(negedge ref_clk_i) begin
    if (entry_wr === 1'b1) last_entry = entry;
    if (irq === 1'b1) n_irq++;
    if (disc === 1'b1) n_disc++;
    if (preempt === 1'b1) n_pre++;
  end

  // ==================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cpu_req <= '{w, !w, a, d};
    @(posedge ref_clk_i);
    cpu_req <= '0;
    // read data stands from the taking edge until the next read
    @(posedge ref_clk_i);
    rv = rdata;
  endtask

  task automatic pulse(input int n, input logic pd, input logic pp);
    repeat (n) begin
      @(posedge ref_clk_i);
      rx_ev.push_data <= pd;
      rx_ev.pop <= pp;
    end
    @(posedge ref_clk_i);
    rx_ev.push_data <= 1'b0;
    rx_ev.pop <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  // status read ahead of each pop
  task automatic drain(input int n);
    repeat (n) begin
      acc(1'b0, `RX_LINK_STATUS_ADDR, 8'h00);
      pulse(1, 1'b0, 1'b1);
    end
  endtask

  task automatic stat(input logic [7:0] exp);
    acc(1'b0, `RX_LINK_STATUS_ADDR, 8'h00);
    check("status", rv, exp);
  endtask

  task automatic wait_octets(input int target);
    int k;
    k = 0;
    while (far_u.got.size() < target && k < 400) begin
      @(posedge ref_clk_i);
      k++;
    end
    check("octet count", 16'(far_u.got.size()), 16'(target));
  endtask

  task automatic rep(input int b, input logic [7:0] o0, input logic [7:0] hi,
      input logic [7:0] lo);
    logic [7:0] hdr [5];
    hdr = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00};
    check("octet0", far_u.got[b], o0);
    for (int i = 0; i < 5; i++) check("header", far_u.got[b+1+i], hdr[i]);
    check("newest hi", far_u.got[b+6], hi);
    check("newest lo", far_u.got[b+7] & 8'hFC, lo);
  endtask

  // ==================================================
  // scenarios
  task automatic t_reset();
    acc(1'b0, `REPORT_CTRL_ADDR, 8'h00);
    check("ctrl reset", rv, `REPORT_CTRL_RESET);
    acc(1'b1, `RX_LINK_STATUS_ADDR, 8'hFF);
    stat(8'h04);
    acc(1'b0, 8'hA8, 8'h00);
    check("unmapped", rv, 8'h00);
    // a lone status entry clears the empty flag and shows as next status
    rx_ev.head_is_status <= 1'b1;
    rx_ev.push_status <= 1'b1;
    @(posedge ref_clk_i);
    rx_ev.push_status <= 1'b0;
    stat(8'h08);
    rx_ev.head_is_status <= 1'b0;
    drain(1);
  endtask

  task automatic t_fifo();
    thr <= 6'h02;
    rx_ev.msg_active <= 1'b1;
    pulse(61, 1'b1, 1'b0);
    stat(8'h10);
    pulse(1, 1'b1, 1'b0);
    stat(8'h12);
    check("near irq", 16'(n_irq), 16'h1);
    check("partial eom", last_entry[7:6], `EOM_PARTIAL);
    pulse(3, 1'b1, 1'b0);
    stat(8'h13);
    check("discard", 16'(n_disc), 16'h1);
    check("overflow entry", last_entry, 8'hC0);
    drain(3);
    stat(8'h10);
    check("no re-irq", 16'(n_irq), 16'h1);
    pulse(1, 1'b1, 1'b0);
    check("re-armed irq", 16'(n_irq), 16'h2);
    rx_ev.msg_active <= 1'b0;
    drain(62);
    stat(8'h04);
  endtask

  task automatic t_send_now();
    acc(1'b1, `REPORT_CTRL_ADDR, 8'h75);
    repeat (20) @(posedge ref_clk_i);
    #1;
    check("busy", busy, 1'b1);
    check("held back", 16'(far_u.got.size()), 16'h0);
    acc(1'b0, `REPORT_CTRL_ADDR, 8'h00);
    check("one-shot", rv, 8'h74);
    // transmit fifo empties after the report has been requested and held in wait
    slow <= 1'b1;
    txe <= 1'b1;
    wait_octets(14);
    rep(0, 8'h3A, 8'h12, 8'h08);
    repeat (40) @(posedge ref_clk_i);
    check("single report", 16'(far_u.got.size()), 16'd14);
    check("no preempt", 16'(n_pre), 16'h0);
  endtask

  task automatic t_auto();
    slow <= 1'b0;
    // counts come in latched once a second, as software enables auto reports and auto slip select
    errs <= '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    prio <= `PRIO_LINK_FIRST;
    acc(1'b1, `REPORT_CTRL_ADDR, 8'h82);
    @(posedge ref_clk_i);
    slip <= 1'b1;
    @(posedge ref_clk_i);
    slip <= 1'b0;
    repeat (30) @(posedge ref_clk_i);
    check("no tick no report", 16'(far_u.got.size()), 16'd14);
    tick <= 1'b1;
    @(posedge ref_clk_i);
    tick <= 1'b0;
    wait_octets(28);
    rep(14, 8'h38, 8'h02, 8'h50);
    check("preempt seen", 16'(n_pre != 0), 16'h1);
    acc(1'b1, `REPORT_CTRL_ADDR, 8'h00);
  endtask

  // ==================================================
  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    cpu_req = '0;
    rx_ev = '0;
    thr = 6'h00;
    tick = 1'b0;
    errs = '0;
    slip = 1'b0;
    prio = 2'h0;
    txe = 1'b0;
    slow = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_fifo();
    t_send_now();
    t_auto();
    results();
  end

  // watchdog well past the expected run of under a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
